// [logic/eld_loopback.sv]
// loopback diagnostic path: dma fetch, serializer, receiver, fifo port
// assumes a buffer memory with a one-cycle ack and a serial codec
//
// Behaviour
// - select 01 ties serializer to deserializer
// - select 10 raises codec loop control
// - select 11 loops through the external medium
// - twisted pair link failure blocks transmitter under select 11 only
// - any loopback splits fifo into halves
// - memory fetches are byte fields only
// - dma fills fifo, decrements count, threshold
// - 56 preamble bits then 8-bit synch
// - crc appended unless crc bit set
// - completion sets packet sent flag
// - receiver checks destination address match
// - receive half wraps, keeps last eight
// - append low, high, high byte count
// - fifo reads advance pointer after sync
// - read during pending advance waits
// - internal loop reports carrier, heartbeat lost
// - packet received flag stays clear
`timescale 1ns/1ps
module eld_loopback
  import eld_pkg::*;
#(
  parameter int BIT_DIV = 2,
  parameter int HALF    = FIFO_HALF
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             fifo_wait_o,
  output logic             mem_req_o,
  output logic      [15:0] mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_data_i,
  output logic             ser_tx_o,
  output logic             tx_en_o,
  output logic             codec_loop_control_o,
  input  wire logic        ser_rx_i,
  input  wire logic        carrier_i,
  input  wire logic        heartbeat_i,
  input  wire logic        link_fail_i
);
  localparam int PW = $clog2(HALF);
  if (BIT_DIV < 1 || HALF < 8 || (1 << PW) != HALF) begin : g_chk
    $error("eld_loopback: bad BIT_DIV or HALF");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] s1_reg, s2_reg;
  always_ff @(posedge ref_clk_i) begin
    s1_reg <= {ser_rx_i, carrier_i, heartbeat_i, link_fail_i};
    s2_reg <= s1_reg;
  end
  wire rx_pin = s2_reg[3];
  wire crs_s  = s2_reg[2];
  wire hb_s   = s2_reg[1];
  wire lf_s   = s2_reg[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0]   lsel_reg;
  logic         crc_inh_reg, wts_reg, bos_reg;
  logic [7:0]   tps_reg, thr_reg;
  logic [15:0]  cnt_reg;
  logic [7:0]   phys_reg [6];
  logic         ptx_reg, crs_lost_reg, cdh_miss_reg, match_reg, bc_reg;
  logic         seen_crs_reg, seen_hb_reg;
  eld_tx_state_t state_reg;

  wire loop_on = |lsel_reg;
  wire mode1   = (lsel_reg == 2'b01);
  wire mode3   = (lsel_reg == 2'b11);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == ELD_CTRL);
  // go looks at the select being written, not the one held before it
  wire go      = wr_ctrl && reg_wdata_i[CTRL_GO]
                 && (reg_wdata_i[1:0] != 2'b00) && (state_reg == TX_IDLE);
  wire [3:0] phys_idx = reg_addr_i[5:2] - 4'h9;
  wire phys_hit = (reg_addr_i >= ELD_PHYS0) && (reg_addr_i <= ELD_PHYS5)
                  && (reg_addr_i[1:0] == 2'b00);

  assign codec_loop_control_o = (lsel_reg == 2'b10);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lsel_reg    <= 2'b00;
      crc_inh_reg <= 1'b0;
      wts_reg     <= 1'b0;
      bos_reg     <= 1'b0;
      tps_reg     <= 8'h00;
      thr_reg     <= THR_RST;
      for (int i = 0; i < 6; i++) phys_reg[i] <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ELD_CTRL && state_reg == TX_IDLE) begin
        lsel_reg    <= reg_wdata_i[CTRL_LSEL_HI:CTRL_LSEL_LO];
        crc_inh_reg <= reg_wdata_i[CTRL_CRC_INH];
      end
      if (reg_addr_i == ELD_DCFG) begin
        wts_reg <= reg_wdata_i[DCFG_WTS];
        bos_reg <= reg_wdata_i[DCFG_BOS];
      end
      if (reg_addr_i == ELD_TPS) tps_reg <= reg_wdata_i;
      if (reg_addr_i == ELD_THR) thr_reg <= reg_wdata_i;
      if (phys_hit) phys_reg[phys_idx[2:0]] <= reg_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // transmit half and local dma
  // ---------------------------------------------------------------
  logic [7:0]    tx_mem [HALF];
  logic [PW:0]   tx_wp_reg, tx_rp_reg;
  logic [15:0]   dma_addr_reg, send_left_reg;
  logic          burst_reg, pop;
  wire  [PW:0]   occ    = tx_wp_reg - tx_rp_reg;
  wire           full   = (occ == PW'(0) + (PW+1)'(HALF));
  wire  [15:0]   step   = wts_reg ? 16'h0002 : 16'h0001;
  wire  [7:0]    lane   = bos_reg ? mem_data_i[15:8] : mem_data_i[7:0];
  wire           tx_run = (state_reg != TX_IDLE) && (state_reg != TX_DONE);

  assign mem_req_o  = tx_run && burst_reg && (cnt_reg != 16'h0000) && !full;
  assign mem_addr_o = dma_addr_reg;
  wire   take       = mem_req_o && mem_ack_i;

  always_ff @(posedge ref_clk_i) begin
    if (take) tx_mem[tx_wp_reg[PW-1:0]] <= lane;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_reg      <= 16'h0000;
      dma_addr_reg <= 16'h0000;
      tx_wp_reg    <= '0;
      burst_reg    <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == ELD_TXCL) cnt_reg[7:0]  <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ELD_TXCH) cnt_reg[15:8] <= reg_wdata_i;
      if (go) begin
        dma_addr_reg <= {tps_reg, 8'h00};
        tx_wp_reg    <= '0;
        burst_reg    <= 1'b1;
      end else if (take) begin
        dma_addr_reg <= dma_addr_reg + step;
        cnt_reg      <= (cnt_reg > step) ? cnt_reg - step : 16'h0000;
        tx_wp_reg    <= tx_wp_reg + 1'b1;
      end
      if (!go && full) burst_reg <= 1'b0;
      else if (!go && {{(7-PW){1'b0}}, occ} < thr_reg) burst_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // serializer
  // ---------------------------------------------------------------
  logic [$clog2(BIT_DIV+1)-1:0] div_reg;
  wire bit_en = (div_reg == '0);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || bit_en) div_reg <= $bits(div_reg)'(BIT_DIV - 1);
    else div_reg <= div_reg - 1'b1;
  end

  logic [5:0]  pre_reg;
  logic [4:0]  crc_cnt_reg;
  logic [2:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic [31:0] crc_reg;
  logic        tx_bit_reg, tx_en_reg;
  wire  [7:0]  head = tx_mem[tx_rp_reg[PW-1:0]];
  wire   pre_bit = ~pre_reg[0] | (pre_reg == PRE_LAST);
  wire   cur_bit = (state_reg == TX_PRE)  ? pre_bit :
                   (state_reg == TX_DATA) ? sh_reg[bit_reg] : ~crc_reg[0];
  wire   crc_fb  = crc_reg[0] ^ sh_reg[bit_reg];
  wire   byte_end = bit_en && (state_reg == TX_DATA) && (bit_reg == 3'h7);
  assign pop = (bit_en && state_reg == TX_PRE && pre_reg == PRE_LAST)
               || (byte_end && send_left_reg != 16'h0000 && occ != '0);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg     <= TX_IDLE;
      pre_reg       <= 6'h00;
      crc_cnt_reg   <= 5'h00;
      bit_reg       <= 3'h0;
      sh_reg        <= 8'h00;
      crc_reg       <= 32'hFFFFFFFF;
      tx_rp_reg     <= '0;
      send_left_reg <= 16'h0000;
      tx_bit_reg    <= 1'b0;
      tx_en_reg     <= 1'b0;
    end else begin
      if (pop) begin
        sh_reg        <= head;
        tx_rp_reg     <= tx_rp_reg + 1'b1;
        send_left_reg <= send_left_reg - 16'h0001;
      end
      if (bit_en) begin
        tx_bit_reg <= cur_bit;
        tx_en_reg  <= tx_run && !(state_reg == TX_PRE && pre_reg == 6'h00 && occ == '0);
      end
      case (state_reg)
        TX_IDLE: if (go) begin
          state_reg     <= TX_PRE;
          pre_reg       <= 6'h00;
          tx_rp_reg     <= '0;
          crc_reg       <= 32'hFFFFFFFF;
          send_left_reg <= wts_reg ? {1'b0, cnt_reg[15:1]} : cnt_reg;
        end
        // preamble waits for the first fetched byte before it starts
        TX_PRE: if (bit_en && (pre_reg != 6'h00 || occ != '0)) begin
          pre_reg <= pre_reg + 6'h01;
          if (pre_reg == PRE_LAST) begin
            state_reg <= TX_DATA;
            bit_reg   <= 3'h0;
          end
        end
        TX_DATA: if (bit_en) begin
          bit_reg <= bit_reg + 3'h1;
          crc_reg <= {1'b0, crc_reg[31:1]} ^ (crc_fb ? CRC_POLY : 32'h0);
          if (byte_end && !pop) begin
            state_reg   <= crc_inh_reg ? TX_DONE : TX_CRC;
            crc_cnt_reg <= 5'h00;
          end
        end
        TX_CRC: if (bit_en) begin
          crc_reg     <= {1'b0, crc_reg[31:1]};
          crc_cnt_reg <= crc_cnt_reg + 5'h01;
          if (crc_cnt_reg == CRC_LAST) state_reg <= TX_DONE;
        end
        TX_DONE: if (bit_en) state_reg <= TX_IDLE;
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

  assign ser_tx_o = tx_bit_reg;
  assign tx_en_o  = tx_en_reg && !(mode3 && lf_s);

  // ---------------------------------------------------------------
  // transmit status
  // ---------------------------------------------------------------
  wire done = (state_reg == TX_DONE) && bit_en;
  wire clr_ptx = reg_wr_i && (reg_addr_i == ELD_ISTAT) && reg_wdata_i[IST_PTX];
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ptx_reg      <= 1'b0;
      crs_lost_reg <= 1'b0;
      cdh_miss_reg <= 1'b0;
      seen_crs_reg <= 1'b0;
      seen_hb_reg  <= 1'b0;
    end else begin
      if (done) ptx_reg <= 1'b1;
      else if (clr_ptx) ptx_reg <= 1'b0;
      if (go) begin
        seen_crs_reg <= 1'b0;
        seen_hb_reg  <= 1'b0;
      end else begin
        if (crs_s) seen_crs_reg <= 1'b1;
        if (hb_s) seen_hb_reg <= 1'b1;
      end
      if (done) begin
        crs_lost_reg <= mode1 || !seen_crs_reg;
        cdh_miss_reg <= mode1 || !seen_hb_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // receiver into the receive half
  // ---------------------------------------------------------------
  logic [7:0]    rx_mem [HALF];
  logic [PW-1:0] rx_wp_reg;
  logic [7:0]    rsh_reg;
  logic [2:0]    rbit_reg;
  logic [15:0]   rn_reg;
  logic [1:0]    app_reg;
  logic          rsync_reg;
  wire rx_bit = mode1 ? tx_bit_reg : rx_pin;
  wire rx_car = mode1 ? tx_en_reg : crs_s;
  wire [7:0] rbyte = {rx_bit, rsh_reg[7:1]};
  wire got = bit_en && loop_on && rx_car && rsync_reg && (rbit_reg == 3'h7);
  wire app = (app_reg != 2'b00);
  wire rx_we = got || app;
  wire [7:0] rx_wd = got ? rbyte : (app_reg == APPEND_STEPS) ? rn_reg[7:0] : rn_reg[15:8];

  always_ff @(posedge ref_clk_i) begin
    if (rx_we) rx_mem[rx_wp_reg] <= rx_wd;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_wp_reg <= '0;
      rsh_reg   <= 8'h00;
      rbit_reg  <= 3'h0;
      rn_reg    <= 16'h0000;
      app_reg   <= 2'b00;
      rsync_reg <= 1'b0;
      match_reg <= 1'b0;
      bc_reg    <= 1'b0;
    end else begin
      if (rx_we) rx_wp_reg <= rx_wp_reg + 1'b1;
      if (app) app_reg <= app_reg - 2'b01;
      if (bit_en && loop_on) begin
        if (rx_car) begin
          rsh_reg <= rbyte;
          if (!rsync_reg && rsh_reg[7] && rx_bit) begin
            rsync_reg <= 1'b1;
            rbit_reg  <= 3'h0;
            rn_reg    <= 16'h0000;
            rx_wp_reg <= '0;
            match_reg <= 1'b1;
            bc_reg    <= 1'b1;
          end else if (rsync_reg) begin
            rbit_reg <= rbit_reg + 3'h1;
          end
          if (got) begin
            rn_reg <= rn_reg + 16'h0001;
            if (rn_reg < 16'h0006) begin
              match_reg <= match_reg && (rbyte == phys_reg[rn_reg[2:0]]);
              bc_reg    <= bc_reg && (rbyte == 8'hFF);
            end
          end
        end else begin
          // a stale last bit would fake the synch pair at the next frame
          rsh_reg <= 8'h00;
          if (rsync_reg) begin
            rsync_reg <= 1'b0;
            app_reg   <= APPEND_STEPS;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fifo read port and register reads
  // ---------------------------------------------------------------
  logic [PW-1:0] rd_ptr_reg;
  logic [2:0]    adv_reg;
  logic          held_reg;
  logic [7:0]    rdata_reg;
  logic [7:0]    rd_mux;
  wire fifo_rd = reg_rd_i && (reg_addr_i == ELD_FIFO);
  wire busy    = (adv_reg != 3'h0);
  wire serve   = (fifo_rd || held_reg) && !busy;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      ELD_CTRL:  rd_mux = {5'h00, crc_inh_reg, lsel_reg};
      ELD_DCFG:  rd_mux = {6'h00, bos_reg, wts_reg};
      ELD_TXCL:  rd_mux = cnt_reg[7:0];
      ELD_TXCH:  rd_mux = cnt_reg[15:8];
      ELD_TPS:   rd_mux = tps_reg;
      ELD_THR:   rd_mux = thr_reg;
      ELD_ISTAT: rd_mux = 8'(ptx_reg) << IST_PTX;
      ELD_TSTAT: rd_mux = (8'(crs_lost_reg) << TST_CRS) | (8'(cdh_miss_reg) << TST_CDH)
                        | (8'(match_reg | bc_reg) << TST_MATCH) | (8'(lf_s) << TST_LINKF);
      default:   rd_mux = phys_hit ? phys_reg[phys_idx[2:0]] : 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_ptr_reg <= '0;
      adv_reg    <= 3'h0;
      held_reg   <= 1'b0;
      rdata_reg  <= 8'h00;
    end else begin
      if (go) rd_ptr_reg <= '0;
      else if (adv_reg == 3'h1) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (serve) begin
        rdata_reg <= rx_mem[rd_ptr_reg];
        adv_reg   <= FIFO_SYNC_CYC;
        held_reg  <= 1'b0;
      end else begin
        if (busy) adv_reg <= adv_reg - 3'h1;
        if (fifo_rd) held_reg <= 1'b1;
      end
      if (reg_rd_i && !fifo_rd) rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign fifo_wait_o = held_reg;
endmodule // eld_loopback

// [logic/eld_pkg.sv]
// constants of the ethernet loopback diagnostic block
// assumes one 25 MHz clock and a byte-wide register port
package eld_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] ELD_CTRL  = 6'h00;
  localparam logic [5:0] ELD_DCFG  = 6'h04;
  localparam logic [5:0] ELD_TXCL  = 6'h08;
  localparam logic [5:0] ELD_TXCH  = 6'h0C;
  localparam logic [5:0] ELD_TPS   = 6'h10;
  localparam logic [5:0] ELD_THR   = 6'h14;
  localparam logic [5:0] ELD_ISTAT = 6'h18;
  localparam logic [5:0] ELD_TSTAT = 6'h1C;
  localparam logic [5:0] ELD_FIFO  = 6'h20;
  localparam logic [5:0] ELD_PHYS0 = 6'h24;
  localparam logic [5:0] ELD_PHYS5 = 6'h38;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_LSEL_LO = 0;
  localparam int CTRL_LSEL_HI = 1;
  localparam int CTRL_CRC_INH = 2;
  localparam int CTRL_GO      = 3;
  localparam int DCFG_WTS     = 0;
  localparam int DCFG_BOS     = 1;
  localparam int IST_PRX      = 0;
  localparam int IST_PTX      = 1;
  localparam int TST_CRS      = 2;
  localparam int TST_CDH      = 4;
  localparam int TST_MATCH    = 5;
  localparam int TST_LINKF    = 6;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] THR_RST       = 8'h04;
  localparam logic [5:0] PRE_LAST      = 6'h3F;
  localparam int         PREAMBLE_BITS = 56;
  localparam int         SYNCH_BITS    = 8;
  localparam logic [4:0] CRC_LAST      = 5'h1F;
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
  localparam logic [2:0] FIFO_SYNC_CYC = 3'h4;
  localparam int         FIFO_HALF     = 8;
  localparam logic [1:0] APPEND_STEPS  = 2'h3;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_PRE  = 5'b00010,
    TX_DATA = 5'b00100,
    TX_CRC  = 5'b01000,
    TX_DONE = 5'b10000
  } eld_tx_state_t;
endpackage

// [dv/eld_loopback_checker.sv]
// concurrent checks on the loopback block's ports
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
module eld_loopback_checker
  import eld_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        fifo_wait_o,
  input wire logic        mem_req_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic        ser_tx_o,
  input wire logic        tx_en_o,
  input wire logic        codec_loop_control_o,
  input wire logic        link_fail_i
);
  // ------
  // shadow of host settings
  // ------
  logic [1:0] lsel_reg;
  logic       word_reg;
  wire        fifo_rd = reg_rd_i && reg_addr_i == ELD_FIFO;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lsel_reg <= 2'h0;
      word_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ELD_CTRL) begin
      lsel_reg <= reg_wdata_i[1:0];
    end else if (reg_wr_i && reg_addr_i == ELD_DCFG) begin
      word_reg <= reg_wdata_i[DCFG_WTS];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  // ------
  // assertions
  // ------
  a_reset_quiet: assert property (rst_i |=> !mem_req_o && !tx_en_o && !fifo_wait_o && !ser_tx_o
    && !codec_loop_control_o && reg_rdata_o == 8'h00 && mem_addr_o == 16'h0000)
    else $error("outputs not idle after reset");
  a_codec_loop_sel: assert property (disable iff (rst_i)
    codec_loop_control_o == (lsel_reg == 2'b10)) else $error("codec loop control wrong");
  a_link_fail_block: assert property (disable iff (rst_i)
    (lsel_reg == 2'b11 && link_fail_i) [*5] |-> !tx_en_o) else $error("tx during link fail");
  a_fifo_wait_rise: assert property (disable iff (rst_i)
    (fifo_rd && !fifo_wait_o) ##[1:3] fifo_rd |-> ##[0:2] fifo_wait_o)
    else $error("close fifo read not held");
  a_fifo_wait_bound: assert property (disable iff (rst_i)
    $rose(fifo_wait_o) |-> ##[1:6] !fifo_wait_o) else $error("fifo wait too long");
  a_mem_req_hold: assert property (disable iff (rst_i)
    mem_req_o && !mem_ack_i |=> mem_req_o) else $error("request dropped before ack");
  a_mem_byte_step: assert property (disable iff (rst_i)
    mem_req_o && mem_ack_i |=> mem_addr_o == $past(mem_addr_o) + (word_reg ? 16'h0002 : 16'h0001))
    else $error("fetch address step wrong");
  a_prx_stays_clear: assert property (disable iff (rst_i)
    reg_rd_i && reg_addr_i == ELD_ISTAT |=> !reg_rdata_o[IST_PRX]) else $error("prx set");
  a_unmapped_zero: assert property (disable iff (rst_i)
    reg_rd_i && reg_addr_i == 6'h3C |=> reg_rdata_o == 8'h00) else $error("unmapped nonzero");
  c_fifo_wait: cover property ($rose(fifo_wait_o));
  c_tx_start: cover property ($rose(tx_en_o));
  c_mem_xfer: cover property (mem_req_o && mem_ack_i);
  c_codec_tx: cover property (codec_loop_control_o && tx_en_o);
endmodule // eld_loopback_checker

bind eld_loopback eld_loopback_checker eld_loopback_checker_inst (.ref_clk_i, .rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fifo_wait_o, .mem_req_o,
  .mem_addr_o, .mem_ack_i, .ser_tx_o, .tx_en_o, .codec_loop_control_o, .link_fail_i);

// [dv/eld_mem_codec_model.sv]
// buffer memory with slow acks, plus codec and cable loop
// assumes the bench fills mem directly before each test
`timescale 1ns/1ps
module eld_mem_codec_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        bos_i,
  output logic             mem_ack_o,
  output logic      [15:0] mem_data_o,
  input  wire logic        ser_tx_i,
  input  wire logic        tx_en_i,
  input  wire logic        loop_ctl_i,
  output logic             ser_rx_o,
  output logic             carrier_o,
  output logic             heartbeat_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] last_reg;
  logic [1:0]  wait_reg;
  logic [2:0]  hb_reg;
  logic        en_reg;
  // addressed byte on the high lane when byte order is set
  wire  [15:0] word = bos_i ? {mem[mem_addr_i], mem[mem_addr_i ^ 16'h0001]}
                            : {mem[mem_addr_i ^ 16'h0001], mem[mem_addr_i]};
  // released lane shows inverse, not the stale word
  assign mem_data_o  = mem_ack_o ? word : ~last_reg;
  assign ser_rx_o    = (tx_en_i || loop_ctl_i) ? ser_tx_i : 1'b0;
  assign carrier_o   = en_reg;
  assign heartbeat_o = hb_reg != 3'h0;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      wait_reg  <= 2'h0;
      last_reg  <= 16'h0000;
      hb_reg    <= 3'h0;
      en_reg    <= 1'b0;
    end else begin
      en_reg    <= tx_en_i;
      hb_reg    <= (en_reg && !tx_en_i) ? 3'h4 : (hb_reg != 3'h0 ? hb_reg - 3'h1 : 3'h0);
      mem_ack_o <= 1'b0;
      if (mem_ack_o) last_reg <= word;
      // ack within four cycles, well inside the latency limit
      if (mem_req_i && !mem_ack_o) begin
        if (wait_reg == 2'h0) begin
          mem_ack_o <= 1'b1;
          wait_reg  <= 2'($urandom_range(3, 0));
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
    end
  end
endmodule // eld_mem_codec_model

// [dv/eld_loopback_tb.sv]
// self-checking bench for the loopback diagnostic block
// assumes the memory and codec model and the bound checker
`timescale 1ns/1ps
module eld_loopback_tb;
  import eld_pkg::*;
  logic        ref_clk_i, rst_i, reg_wr_i, reg_rd_i, link_fail_i, bos_q;
  logic [5:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, d;
  logic [15:0] mem_addr_o, mem_data_i;
  logic        fifo_wait_o, mem_req_o, mem_ack_i, ser_tx_o, tx_en_o;
  logic        codec_loop_control_o, ser_rx_i, carrier_i, heartbeat_i;
  logic [7:0]  phys [6];
  logic [7:0]  expb [8];
  int          bad_count, samples_checked, i, k;
  int          t_sel [8] = '{1, 1, 2, 2, 3, 3, 1, 1};
  int          t_crc [8] = '{0, 1, 0, 1, 0, 1, 0, 1};
  int          t_wts [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
  int          t_bos [8] = '{0, 0, 0, 0, 0, 0, 0, 1};
  int          t_len [8] = '{19, 11, 13, 21, 27, 8, 16, 29};

  eld_loopback #(.BIT_DIV(1)) eld_loopback_inst (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fifo_wait_o, .mem_req_o, .mem_addr_o, .mem_ack_i,
    .mem_data_i, .ser_tx_o, .tx_en_o, .codec_loop_control_o, .ser_rx_i, .carrier_i,
    .heartbeat_i, .link_fail_i);
  eld_mem_codec_model eld_mem_codec_model_inst (.ref_clk_i, .rst_i, .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .bos_i(bos_q), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i),
    .ser_tx_i(ser_tx_o), .tx_en_i(tx_en_o), .loop_ctl_i(codec_loop_control_o),
    .ser_rx_o(ser_rx_i), .carrier_o(carrier_i), .heartbeat_o(heartbeat_i));

  // ------
  // bus tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    int n;
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    n = 0;
    // held fifo read: answer is loaded on the edge that drops the wait; sampled a cycle later
    if (fifo_wait_o === 1'b1) begin
      while (fifo_wait_o !== 1'b0 && n < 20) begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      if (n == 20) bad_count++;
      @(posedge ref_clk_i);
      #1;
    end
    v = reg_rdata_o;
    @(posedge ref_clk_i);
  endtask
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ 32'(b);
    repeat (8) r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
    return r;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------
  // one loopback packet, expectation built alongside
  // ------
  task automatic run_pkt(input int sel, crc_inh, word_transfer_select, byte_order_select, len, dkind);
    logic [7:0]  s[$];
    logic [31:0] c;
    logic [15:0] base, cnt;
    int          n, j;
    base = {2'h0, 6'($urandom_range(63, 1)), 8'h00};
    for (n = 0; n < len; n++) begin
      s.push_back(n < 6 ? (dkind == 0 ? phys[n] : dkind == 1 ? 8'hFF : phys[n] ^ 8'h01)
                        : 8'($urandom));
      eld_mem_codec_model_inst.mem[base + 16'(n * 2 + 1)] = 8'($urandom);
      eld_mem_codec_model_inst.mem[base + 16'(n * (word_transfer_select + 1))] = s[n];
    end
    c = 32'hFFFFFFFF;
    foreach (s[m]) c = crc_byte(c, s[m]);
    if (crc_inh == 0) for (j = 0; j < 4; j++) s.push_back(8'((~c) >> (8 * j)));
    cnt = 16'(s.size());
    s.push_back(cnt[7:0]);
    s.push_back(cnt[15:8]);
    s.push_back(cnt[15:8]);
    foreach (s[m]) expb[m % 8] = s[m];
    bos_q <= 1'(byte_order_select);
    wr(ELD_DCFG, 8'(byte_order_select * 2 + word_transfer_select));
    wr(ELD_TPS, base[15:8]);
    cnt = 16'(len * (word_transfer_select + 1));
    wr(ELD_TXCL, cnt[7:0]);
    wr(ELD_TXCH, cnt[15:8]);
    wr(ELD_CTRL, 8'(8 + crc_inh * 4 + sel));
    j = 0;
    d = 8'h00;
    while (d[IST_PTX] !== 1'b1 && j < 3000) begin
      rd(ELD_ISTAT, d);
      j++;
    end
    check("sent flag", d[IST_PTX], 1);
    check("recv flag", d[IST_PRX], 0);
    repeat (40) @(posedge ref_clk_i);
    rd(ELD_TSTAT, d);
    check("addr match", d[TST_MATCH], dkind != 2);
    if (sel == 1) check("blocked codec", {d[TST_CDH], d[TST_CRS]}, 2'b11);
    rd(ELD_TXCL, d);
    check("count left", d, 0);
    wr(ELD_ISTAT, 8'h02);
    rd(ELD_ISTAT, d);
    check("sent clear", d[IST_PTX], 0);
    // first two reads close together to force a wait
    for (j = 0; j < 8; j++) begin
      rd(ELD_FIFO, d);
      check("fifo byte", d, expb[j]);
      if (j > 0) repeat (4) @(posedge ref_clk_i);
    end
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #(40 * 90000);
    bad_count++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    bad_count       = 0;
    samples_checked = 0;
    rst_i           = 1'b1;
    reg_wr_i        = 1'b0;
    reg_rd_i        = 1'b0;
    reg_addr_i      = 6'h00;
    reg_wdata_i     = 8'h00;
    link_fail_i     = 1'b0;
    bos_q           = 1'b0;
    void'($urandom(88));
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(ELD_THR, d);
    check("thr reset", d, THR_RST);
    rd(ELD_ISTAT, d);
    check("istat reset", d, 8'h00);
    rd(6'h3C, d);
    check("unmapped", d, 8'h00);
    for (i = 0; i < 6; i++) begin
      phys[i] = 8'($urandom) & 8'hFC;
      wr(ELD_PHYS0 + 6'(4 * i), phys[i]);
    end
    rd(ELD_PHYS5, d);
    check("station byte", d, phys[5]);
    for (k = 0; k < 12; k++) begin
      if (k < 8) run_pkt(t_sel[k], t_crc[k], t_wts[k], t_bos[k], t_len[k], k % 3);
      else run_pkt($urandom_range(3, 1), $urandom_range(1, 0), 0, 0, $urandom_range(30, 8),
                   $urandom_range(2, 0));
      $display("test %0d done", k);
    end
    // link failure last: link_fail_i stays set to the end of the run
    link_fail_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    wr(ELD_TXCL, 8'h08);
    wr(ELD_CTRL, 8'h0B);
    k = 0;
    repeat (300) begin
      @(posedge ref_clk_i);
      if (tx_en_o !== 1'b0) k++;
    end
    check("tx blocked", k, 0);
    rd(ELD_TSTAT, d);
    check("link fail seen", d[TST_LINKF], 1);
    $display("test link fail done");
    report_and_stop();
  end
endmodule // eld_loopback_tb
